// ==== shared/fdrv_pkg.sv ====
// Package of constants and carrier types for the flash driver flag and config bank
package fdrv_pkg;

  localparam int          FDRV_DATA_W         = 8;
  localparam int          FDRV_ADDR_W         = 8;

  // Register addresses as seen from the serial engine
  localparam logic [7:0]  FDRV_ADDR_STATUS    = 8'hd0;
  localparam logic [7:0]  FDRV_ADDR_CONFIG1   = 8'he0;

  // Status flag positions
  localparam int          FDRV_FLG_TIMEOUT    = 0;
  localparam int          FDRV_FLG_THERMAL    = 1;
  localparam int          FDRV_FLG_LEDFAULT   = 2;
  localparam int          FDRV_FLG_SYNCONE    = 3;
  localparam int          FDRV_FLG_SYNCTWO    = 4;
  localparam int          FDRV_FLG_THERMISTOR = 5;
  localparam int          FDRV_FLG_FLASHSUP   = 6;
  localparam int          FDRV_FLG_SUPPLY     = 7;
  localparam logic [7:0]  FDRV_STATUS_RESET   = 8'h00;

  // Configuration one field positions
  localparam int          FDRV_CFG_STROBE_EN  = 2;
  localparam int          FDRV_CFG_STROBE_POL = 3;
  localparam int          FDRV_CFG_THERM_MODE = 4;
  localparam int          FDRV_CFG_SYNC1_POL  = 5;
  localparam int          FDRV_CFG_SYNC2_POL  = 6;
  localparam int          FDRV_CFG_LAMP_MODE  = 7;
  localparam logic [7:0]  FDRV_CONFIG1_RESET  = 8'h68;
  localparam logic [7:0]  FDRV_CONFIG1_MASK   = 8'hfc;
  localparam logic [7:0]  FDRV_UNMAPPED_READ  = 8'h00;

  // Inputs that arrive from outside the clock domain, passed through the synchroniser
  typedef struct packed {
    logic strobe;
    logic syncOnePin;
    logic syncTwoPin;
    logic thermistorLow;
    logic supplyLow;
    logic flashSupplyLow;
    logic thermalTrip;
    logic ledFailure;
  } fdrv_pins_type;

  // Register access strobes from the serial engine
  typedef struct packed {
    logic       read;
    logic       write;
    logic [7:0] addr;
    logic [7:0] wdata;
  } fdrv_req_type;

endpackage

// ==== verilog/fdrv_sync.sv ====
// Two-flop synchroniser for a vector of independent level inputs
`timescale 1ns/10ps
module fdrv_sync #(
  parameter int WIDTH = 8
) (
  input  wire logic             clk_sys,
  input  wire logic             resetn,
  input  wire logic [WIDTH-1:0] asyncIn,
  output logic      [WIDTH-1:0] syncOut
);

  logic [WIDTH-1:0] stageOne;

  // Bits are not coherent with each other; only use for independent levels
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      stageOne <= '0;
      syncOut  <= '0;
    end else begin
      stageOne <= asyncIn;
      syncOut  <= stageOne;
    end
  end

endmodule // fdrv_sync

// ==== verilog/fdrv_flag_config.sv ====
// Fault and event status register with clear on read, plus configuration register one
//
// Functional notes
// - Reading the status register clears all its flags, which otherwise stay set.
// - Bits 0, 1 and 2 set on flash timeout, thermal shutdown and LED open or short.
// - Bits 3 and 4 set when sync input one or two changes state while in sync mode.
// - Bit 5 needs thermistor mode and a low pin, bit 7 needs the supply monitor and a trip.
// - Bit 6 sets only with the flash-time monitor enabled and a supply drop at turn-on.
// - Config bit 2 enables the strobe pin, which is ignored while it is clear.
// - Config bit 3 picks strobe level, 0 active low and 1 active high.
// - Config bit 4 makes the shared pin a thermistor input instead of an indicator.
// - Config bits 5 and 6 set sync input polarity, 1 active high by default.
// - Config bit 7 makes pin one a torch enable and is cleared after each flash.
`timescale 1ns/10ps
module fdrv_flag_config
  import fdrv_pkg::*;
#(
  parameter int DATA_W = FDRV_DATA_W
) (
  input  wire logic          clk_sys,
  input  wire logic          resetn,
  input  wire fdrv_req_type  regReq,
  output logic [7:0]         regRdata,
  output logic               regRvalid,
  input  wire fdrv_pins_type pinsAsync,
  input  wire logic          flashTimeoutPulse,
  input  wire logic          flashTurnOn,
  input  wire logic          flashDone,
  input  wire logic          supplyMonitorEnable,
  input  wire logic          flashSupplyMonitorEnable,
  input  wire logic          pinOneGpio,
  input  wire logic          pinTwoGpio,
  output logic               strobeFlashRequest,
  output logic               syncOneActive,
  output logic               syncTwoActive,
  output logic               torchRequest,
  output logic               thermistorInputMode,
  output logic [7:0]         configOne
);

  if (DATA_W != 8) begin : gCheck
    $error("fdrv_flag_config supports 8-bit registers only");
  end

  fdrv_pins_type pins;
  logic [7:0]    status;
  logic [7:0]    next_status;
  logic [7:0]    next_configOne;
  logic          syncOnePrev;
  logic          syncTwoPrev;
  logic [7:0]    next_regRdata;
  logic          next_regRvalid;
  logic          next_strobeFlashRequest;
  logic          next_syncOneActive;
  logic          next_syncTwoActive;
  logic          next_torchRequest;
  logic          next_thermistorInputMode;
  logic [7:0]    setMask;
  logic          pinOneSyncMode;
  logic          pinTwoSyncMode;

  fdrv_sync #(
    .WIDTH   ($bits(fdrv_pins_type))
  ) uSync (
    .clk_sys (clk_sys),
    .resetn  (resetn),
    .asyncIn (pinsAsync),
    .syncOut (pins)
  );

  // Active level after polarity correction
  function automatic logic fdrv_level(input logic pin, input logic activeHigh);
    return activeHigh ? pin : ~pin;
  endfunction

  always_comb begin
    pinOneSyncMode = ~configOne[FDRV_CFG_LAMP_MODE] & ~pinOneGpio;
    pinTwoSyncMode = ~pinTwoGpio;
    setMask = 8'h00;
    setMask[FDRV_FLG_TIMEOUT]    = flashTimeoutPulse;
    setMask[FDRV_FLG_THERMAL]    = pins.thermalTrip;
    setMask[FDRV_FLG_LEDFAULT]   = pins.ledFailure;
    setMask[FDRV_FLG_SYNCONE]    = pinOneSyncMode & (pins.syncOnePin ^ syncOnePrev);
    setMask[FDRV_FLG_SYNCTWO]    = pinTwoSyncMode & (pins.syncTwoPin ^ syncTwoPrev);
    setMask[FDRV_FLG_THERMISTOR] = configOne[FDRV_CFG_THERM_MODE] & pins.thermistorLow;
    setMask[FDRV_FLG_SUPPLY]     = supplyMonitorEnable & pins.supplyLow;
    setMask[FDRV_FLG_FLASHSUP]   = flashSupplyMonitorEnable & flashTurnOn
                                   & pins.flashSupplyLow;
  end

  // Status: clear on read, set wins so a coincident event is kept
  always_comb begin
    next_status = status;
    if (regReq.read && regReq.addr == FDRV_ADDR_STATUS) begin
      next_status = 8'h00;
    end
    next_status = next_status | setMask;
  end

  // Config one: hardware clear of torch mode beats a coincident write
  always_comb begin
    next_configOne = configOne;
    if (regReq.write && regReq.addr == FDRV_ADDR_CONFIG1) begin
      next_configOne = regReq.wdata & FDRV_CONFIG1_MASK;
    end
    if (flashDone) begin
      next_configOne[FDRV_CFG_LAMP_MODE] = 1'b0;
    end
  end

  // Read data reflects the value before this cycle's clear
  always_comb begin
    next_regRvalid = regReq.read;
    next_regRdata  = regRdata;
    if (regReq.read) begin
      unique case (regReq.addr)
        FDRV_ADDR_STATUS:  next_regRdata = status;
        FDRV_ADDR_CONFIG1: next_regRdata = configOne & FDRV_CONFIG1_MASK;
        default:           next_regRdata = FDRV_UNMAPPED_READ;
      endcase
    end
  end

  always_comb begin
    next_strobeFlashRequest  = configOne[FDRV_CFG_STROBE_EN]
                               & fdrv_level(pins.strobe, configOne[FDRV_CFG_STROBE_POL]);
    next_syncOneActive       = pinOneSyncMode
                               & fdrv_level(pins.syncOnePin, configOne[FDRV_CFG_SYNC1_POL]);
    next_syncTwoActive       = pinTwoSyncMode
                               & fdrv_level(pins.syncTwoPin, configOne[FDRV_CFG_SYNC2_POL]);
    // Torch enable taken as active high on the shared pin
    next_torchRequest        = configOne[FDRV_CFG_LAMP_MODE] & ~pinOneGpio & pins.syncOnePin;
    next_thermistorInputMode = configOne[FDRV_CFG_THERM_MODE];
  end

  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      status              <= FDRV_STATUS_RESET;
      configOne           <= FDRV_CONFIG1_RESET;
      syncOnePrev         <= 1'b0;
      syncTwoPrev         <= 1'b0;
      regRdata            <= 8'h00;
      regRvalid           <= 1'b0;
      strobeFlashRequest  <= 1'b0;
      syncOneActive       <= 1'b0;
      syncTwoActive       <= 1'b0;
      torchRequest        <= 1'b0;
      thermistorInputMode <= 1'b0;
    end else begin
      status              <= next_status;
      configOne           <= next_configOne;
      syncOnePrev         <= pins.syncOnePin;
      syncTwoPrev         <= pins.syncTwoPin;
      regRdata            <= next_regRdata;
      regRvalid           <= next_regRvalid;
      strobeFlashRequest  <= next_strobeFlashRequest;
      syncOneActive       <= next_syncOneActive;
      syncTwoActive       <= next_syncTwoActive;
      torchRequest        <= next_torchRequest;
      thermistorInputMode <= next_thermistorInputMode;
    end
  end

endmodule // fdrv_flag_config

// ==== bench/fdrv_host.sv ====
// Host side model that issues single byte register reads and writes
`timescale 1ns/10ps
module fdrv_host
  import fdrv_pkg::*;
(
  input  wire logic       clk_sys,
  input  wire logic [7:0] regRdata,
  input  wire logic       regRvalid,
  output fdrv_req_type    regReq
);
  initial regReq = '0;
  // Idle address and data are inverted so nothing stale looks like a request
  task automatic xfer(input logic w, input logic [7:0] a, input logic [7:0] d,
                      output logic [8:0] r);
    @(posedge clk_sys) #1;
    regReq = '{read: !w, write: w, addr: a, wdata: d};
    @(posedge clk_sys) #1;
    regReq = '{read: 1'b0, write: 1'b0, addr: ~a, wdata: ~d};
    r = {regRvalid, regRdata};
  endtask
endmodule // fdrv_host

// ==== bench/fdrv_flag_config_chk.sv ====
// Port level assertions for the flag and config bank
`timescale 1ns/10ps
module fdrv_chk
  import fdrv_pkg::*;
(
  input wire logic         clk_sys,
  input wire logic         resetn,
  input wire fdrv_req_type regReq,
  input wire logic [7:0]   regRdata,
  input wire logic         regRvalid,
  input wire logic         flashTimeoutPulse,
  input wire logic         flashDone,
  input wire logic         pinTwoGpio,
  input wire logic         strobeFlashRequest,
  input wire logic         syncTwoActive,
  input wire logic [7:0]   configOne
);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!resetn);
  wire rdS = regReq.read && regReq.addr == FDRV_ADDR_STATUS;
  wire wrC = regReq.write && regReq.addr == FDRV_ADDR_CONFIG1;
  a_read_answer: assert property (regReq.read |=> regRvalid)
    else $error("read not answered");
  // Reads come every other cycle at best, so the gap between them is part of the pattern
  a_read_clears: assert property ((rdS && !flashTimeoutPulse) ##1 !flashTimeoutPulse ##1 rdS
    |=> !regRdata[0])
    else $error("flag survived read");
  a_event_kept: assert property (flashTimeoutPulse ##1 rdS |=> regRdata[0])
    else $error("timeout flag lost");
  a_cfg_write: assert property (wrC && !flashDone |=>
    configOne == ($past(regReq.wdata) & FDRV_CONFIG1_MASK))
    else $error("config write wrong");
  a_cfg_unused: assert property (configOne[1:0] == 2'b00)
    else $error("unused config bits set");
  a_lamp_clear: assert property (flashDone |=> !configOne[FDRV_CFG_LAMP_MODE])
    else $error("torch bit kept");
  a_strobe_gate: assert property (!configOne[FDRV_CFG_STROBE_EN] |=> !strobeFlashRequest)
    else $error("strobe not gated");
  a_sync_gpio: assert property (pinTwoGpio |=> !syncTwoActive)
    else $error("sync two active in gpio");
  a_cfg_read: assert property (regReq.read && regReq.addr == FDRV_ADDR_CONFIG1 && !wrC
    |=> regRdata == $past(configOne))
    else $error("config read wrong");
  c_status_read: cover property (rdS ##1 regRvalid);
  c_flash_done: cover property (flashDone);
  c_cfg_write: cover property (wrC);
endmodule // fdrv_chk
bind fdrv_flag_config fdrv_chk u_chk (.clk_sys(clk_sys), .resetn(resetn), .regReq(regReq),
  .regRdata(regRdata), .regRvalid(regRvalid), .flashTimeoutPulse(flashTimeoutPulse),
  .flashDone(flashDone), .pinTwoGpio(pinTwoGpio), .strobeFlashRequest(strobeFlashRequest),
  .syncTwoActive(syncTwoActive), .configOne(configOne));

// ==== bench/tb_top.sv ====
// Self-checking bench for the flag and config bank
`timescale 1ns/10ps
module tb_top;
  import fdrv_pkg::*;
  logic clk_sys = 0, resetn = 0, tmo = 0, turnOn = 0, done = 0, supEn = 0, fsupEn = 0;
  logic g1 = 0, g2 = 0, rv, sReq, s1, s2, trq, tMode;
  logic [7:0] rdat, cfg, d;
  fdrv_pins_type pins = '0;
  fdrv_req_type  req;
  int err_total = 0, n_tests = 0, expCfg;
  always #20 clk_sys = ~clk_sys;
  fdrv_host host (.clk_sys(clk_sys), .regRdata(rdat), .regRvalid(rv), .regReq(req));
  fdrv_flag_config uut (.clk_sys(clk_sys), .resetn(resetn), .regReq(req), .regRdata(rdat),
    .regRvalid(rv), .pinsAsync(pins), .flashTimeoutPulse(tmo), .flashTurnOn(turnOn),
    .flashDone(done), .supplyMonitorEnable(supEn), .flashSupplyMonitorEnable(fsupEn),
    .pinOneGpio(g1), .pinTwoGpio(g2), .strobeFlashRequest(sReq), .syncOneActive(s1),
    .syncTwoActive(s2), .torchRequest(trq), .thermistorInputMode(tMode), .configOne(cfg));
  task chk(input logic [7:0] got, input logic [7:0] exp);
    n_tests++;
    if (got !== exp) begin
      err_total++;
      $display("FAIL %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task step(input int n);
    repeat (n) @(posedge clk_sys);
    #1;
  endtask
  task rd(input logic [7:0] a, input logic [7:0] exp);
    logic [8:0] r;
    host.xfer(1'b0, a, 8'h00, r);
    chk(8'(r[8]), 8'h01);
    chk(r[7:0], exp);
  endtask
  task wr(input logic [7:0] a, input logic [7:0] v);
    logic [8:0] r;
    host.xfer(1'b1, a, v, r);
  endtask
  // Pin pulse long enough to pass the synchroniser, then two reads
  task ev(input logic [7:0] p, input logic [7:0] exp);
    pins = fdrv_pins_type'(p);
    step(3);
    pins = '0;
    step(4);
    rd(FDRV_ADDR_STATUS, exp);
    rd(FDRV_ADDR_STATUS, 8'h00);
  endtask
  task finish_test;
    $display("tests %0d errors %0d", n_tests, err_total);
    if (err_total == 0 && n_tests > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  initial begin
    #100000;
    err_total++;
    finish_test;
  end
  initial begin
    void'($urandom(9011));
    step(16);
    resetn = 1;
    rd(FDRV_ADDR_STATUS, 8'h00);
    rd(FDRV_ADDR_CONFIG1, 8'h68);
    rd(8'h55, 8'h00);
    for (int i = 0; i < 8; i++) begin
      d = 8'($urandom);
      wr(FDRV_ADDR_CONFIG1, d);
      expCfg = d & 8'hfc;
      chk(cfg, 8'(expCfg));
      rd(FDRV_ADDR_CONFIG1, 8'(expCfg));
      pins.strobe = 1'($urandom);
      step(4);
      chk(8'(sReq), 8'(expCfg[2] & (pins.strobe == expCfg[3])));
      chk(8'(tMode), 8'(expCfg[4]));
      chk(8'(s2), 8'(!expCfg[6]));
      chk(8'(s1), 8'(!expCfg[7] & !expCfg[5]));
    end
    // Reset in mid-run must bring back the defaults over a random setting
    pins = '0;
    resetn = 0;
    step(2);
    chk(8'(tMode), 8'h00);
    chk(cfg, 8'h68);
    resetn = 1;
    rd(FDRV_ADDR_CONFIG1, 8'h68);
    wr(FDRV_ADDR_CONFIG1, 8'hb3);
    pins.syncOnePin = 1;
    step(4);
    chk(8'(trq), 8'h01);
    done = 1;
    step(1);
    done = 0;
    step(2);
    chk(8'(trq), 8'h00);
    rd(FDRV_ADDR_CONFIG1, 8'h30);
    // Pin one is back in sync mode, so its fall is an event
    pins = '0;
    step(4);
    rd(FDRV_ADDR_STATUS, 8'h08);
    fork
      rd(FDRV_ADDR_STATUS, 8'h01);
      begin tmo = 1; step(1); tmo = 0; end
    join
    fork
      rd(FDRV_ADDR_STATUS, 8'h00);
      begin step(1); tmo = 1; step(1); tmo = 0; end
    join
    rd(FDRV_ADDR_STATUS, 8'h01);
    rd(FDRV_ADDR_STATUS, 8'h00);
    ev(8'h03, 8'h06);
    ev(8'h10, 8'h20);
    ev(8'h08, 8'h00);
    supEn = 1;
    ev(8'h08, 8'h80);
    fsupEn = 1;
    ev(8'h04, 8'h00);
    turnOn = 1;
    ev(8'h04, 8'h40);
    ev(8'h20, 8'h10);
    ev(8'h40, 8'h08);
    g1 = 1;
    g2 = 1;
    ev(8'h60, 8'h00);
    wr(FDRV_ADDR_CONFIG1, 8'h68);
    ev(8'h10, 8'h00);
    finish_test;
  end
endmodule // tb_top
